// ===== src/vhp_consts.svh
`ifndef VHP_CONSTS_SVH
`define VHP_CONSTS_SVH

// Command register decode
`define VHP_CMD_DD_SET_BIT   7
`define VHP_CMD_CG_SET_BIT   6
`define VHP_CG_ADDR_MSB      5

// Status byte layout
`define VHP_BUSY_BIT         7
`define VHP_AC_MSB           6

// Display code RAM geometry
`define VHP_DD_DEPTH         80
`define VHP_DD_LAST          7'h4f
`define VHP_LINE_LEN         7'h28
`define VHP_LINE_LAST        7'h27
`define VHP_LINE2_BASE       7'h40
`define VHP_DEV_POSITIONS    7'h18

// User glyph RAM geometry
`define VHP_CG_DEPTH         64

// Serial frame control byte
`define VHP_SER_BITS         4'h8
`define VHP_SER_RW_BIT       2
`define VHP_SER_RS_BIT       1

// Pin synchroniser vector layout
`define VHP_PIN_W            16
`define VHP_PIN_IM           15
`define VHP_PIN_STYLE        14
`define VHP_PIN_CS           13
`define VHP_PIN_RS           12
`define VHP_PIN_EN           11
`define VHP_PIN_RW           10
`define VHP_PIN_SI           9
`define VHP_PIN_W8           8
// Pin levels held in reset: chip select and write strobe released
`define VHP_PIN_IDLE         16'h2400

`endif

// ===== src/vhp_host_port.sv
`timescale 1ns/10ps
`include "vhp_consts.svh"

// How it works
// - Parallel bus, 4 or 8 bits wide, or serial link; one active at a time.
// - Link select pin low picks serial, high picks parallel; host holds it.
// - Two 8-bit registers: command register and transfer register.
// - Command register is write-only; status reads never return it.
// - Select-low write loads command; select-high write stores transfer byte in RAM.
// - Select-low read gives busy on bit 7, address counter bits 6..0.
// - Busy flag always reads low.
// - Address-setting command copies its address part into the address counter.
// - Same command picks display or glyph RAM until the next one.
// - Address counter steps by one after every RAM data write or read.
// - Display RAM holds 80 codes; unused ones are general storage.
// - Display address lives in seven counter bits, bit 6 most significant.
// - One-line mode: addresses 00..4F contiguous, shown from the head.
// - One-line shift: left shows 01 first, right shows 4F first.
// - Two-line mode: lines at 00..27 and 40..67, both from the head.
// - Two-line shift wraps each line inside its own range.
// - Positions 25..40 go to the extension driver, 1..24 to this device.
module vhp_host_port #(
    parameter int FIFO_DEPTH = 2
) (
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    input  wire logic            link_type_select,
    input  wire logic            host_style_select,
    input  wire logic            bus_width8,
    input  wire logic            cs_n,
    input  wire logic            register_select,
    input  wire logic            enable_strobe,
    input  wire logic            read_write,
    input  wire logic            serial_in,
    input  wire logic [7:0]      host_data_pins_in,
    output logic [7:0]           host_data_pins_out,
    output logic                 host_data_pins_oe_n,
    output logic                 serial_out,
    output logic                 serial_oe_n,
    output logic                 write_ready,
    input  wire logic            two_line,
    input  wire logic            shift_left,
    input  wire logic            shift_right,
    input  wire logic            disp_req,
    input  wire logic            disp_line,
    input  wire logic [6:0]      disp_pos,
    output vhp_pkg::vhp_byte_t   disp_code,
    output vhp_pkg::vhp_addr_t   disp_addr,
    output logic                 disp_ext
);
    import vhp_pkg::*;

    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    // Physical display RAM index for an address in the current layout
    function automatic vhp_addr_t phys_idx(input vhp_addr_t a, input logic two);
        if (two && a[6])
            phys_idx = `VHP_LINE_LEN + {1'b0, a[5:0]};
        else
            phys_idx = a;
    endfunction

    // Address lands in a real display RAM cell for the current layout
    function automatic logic dd_valid(input vhp_addr_t a, input logic two);
        dd_valid = two ? (a[5:0] <= 6'(`VHP_LINE_LAST)) : (a <= `VHP_DD_LAST);
    endfunction

    // Address counter step after a RAM transfer
    function automatic vhp_addr_t ac_step(input vhp_addr_t a, input vhp_ram_sel_t s);
        if (s == VHP_SEL_GLYPH)
            ac_step = {1'b0, a[5:0] + 6'h01};
        else
            ac_step = a + 7'h01;
    endfunction

    // Pin synchronisers and edge stage; reset to idle levels so no false edge follows reset
    logic [`VHP_PIN_W-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
    logic [`VHP_PIN_W-1:0] pin_raw;
    assign pin_raw = {link_type_select, host_style_select, cs_n, register_select,
                      enable_strobe, read_write, serial_in, bus_width8, host_data_pins_in};
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_ff <= `VHP_PIN_IDLE;
            pin_s2_ff <= `VHP_PIN_IDLE;
            pin_s3_ff <= `VHP_PIN_IDLE;
        end else begin
            pin_s1_ff <= pin_raw;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end

    logic par_mode, style_en, sel_ok, rs_s, en_s, en_p, rw_s, rw_p, w8;
    logic [7:0] db_s;
    assign par_mode = pin_s2_ff[`VHP_PIN_IM];
    assign style_en = pin_s2_ff[`VHP_PIN_STYLE];
    assign sel_ok   = !pin_s2_ff[`VHP_PIN_CS];
    assign rs_s     = pin_s2_ff[`VHP_PIN_RS];
    assign en_s     = pin_s2_ff[`VHP_PIN_EN];
    assign en_p     = pin_s3_ff[`VHP_PIN_EN];
    assign rw_s     = pin_s2_ff[`VHP_PIN_RW];
    assign rw_p     = pin_s3_ff[`VHP_PIN_RW];
    assign w8       = pin_s2_ff[`VHP_PIN_W8];
    assign db_s     = pin_s2_ff[7:0];

    // Parallel strobe decode for both host styles
    logic p_rd_act, p_rd_act_prev, p_wr_done, p_rd_start;
    assign p_rd_act      = par_mode && sel_ok && (style_en ? (en_s && rw_s) : !en_s);
    assign p_rd_act_prev = par_mode && sel_ok && (style_en ? (en_p && rw_p) : !en_p);
    assign p_wr_done     = par_mode && sel_ok &&
                           (style_en ? (en_p && !en_s && !rw_s) : (!rw_p && rw_s));
    assign p_rd_start    = p_rd_act && !p_rd_act_prev;

    // Nibble pairing in 4-bit mode, high nibble first
    logic nib_lo_ff, rd_nib_lo_ff;
    logic [3:0] nib_hi_ff;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            nib_lo_ff <= 1'b0;
            nib_hi_ff <= 4'h0;
        end else if (!par_mode || w8) begin
            nib_lo_ff <= 1'b0;
        end else if (p_wr_done) begin
            nib_lo_ff <= !nib_lo_ff;
            nib_hi_ff <= db_s[7:4];
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            rd_nib_lo_ff <= 1'b0;
        else if (!par_mode || w8)
            rd_nib_lo_ff <= 1'b0;
        else if (p_rd_start)
            rd_nib_lo_ff <= !rd_nib_lo_ff;
    end

    // Serial link: strobe frames, clock rising samples, falling shifts out
    logic stb_s, stb_p, sck_rise, sck_fall, ser_rw_ff, ser_rs_ff;
    logic [3:0] ser_cnt_ff;
    logic [7:0] ser_sh_ff;
    vhp_ser_state_t ser_st_ff;
    logic ser_byte, ser_wr_push, ser_rd_fetch;
    assign stb_s     = !par_mode && !pin_s2_ff[`VHP_PIN_RS] && sel_ok;
    assign stb_p     = !pin_s3_ff[`VHP_PIN_IM] && !pin_s3_ff[`VHP_PIN_RS] && !pin_s3_ff[`VHP_PIN_CS];
    assign sck_rise  = stb_s && en_s && !en_p;
    assign sck_fall  = stb_s && !en_s && en_p;
    assign ser_byte  = sck_rise && (ser_cnt_ff == `VHP_SER_BITS - 4'h1);
    assign ser_wr_push  = ser_byte && (ser_st_ff == VHP_SER_DATA) && !ser_rw_ff;
    assign ser_rd_fetch = ser_byte && (ser_st_ff == VHP_SER_CTRL) && ser_sh_ff[`VHP_SER_RW_BIT - 1];
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_cnt_ff <= 4'h0;
            ser_st_ff  <= VHP_SER_CTRL;
            ser_rw_ff  <= 1'b0;
            ser_rs_ff  <= 1'b0;
        end else if (stb_s && !stb_p) begin
            ser_cnt_ff <= 4'h0;
            ser_st_ff  <= VHP_SER_CTRL;
        end else if (sck_rise) begin
            ser_cnt_ff <= ser_byte ? 4'h0 : ser_cnt_ff + 4'h1;
            if (ser_byte && ser_st_ff == VHP_SER_CTRL) begin
                ser_st_ff <= VHP_SER_DATA;
                ser_rw_ff <= ser_sh_ff[`VHP_SER_RW_BIT - 1];
                ser_rs_ff <= ser_sh_ff[`VHP_SER_RS_BIT - 1];
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            ser_sh_ff <= 8'h00;
        else if (sck_rise)
            ser_sh_ff <= {ser_sh_ff[6:0], pin_s2_ff[`VHP_PIN_SI]};
    end

    // Requests merged from whichever link is active
    logic push_valid, push_rs, rd_fetch, rd_rs;
    vhp_byte_t push_data;
    assign push_valid = ser_wr_push || (p_wr_done && (w8 || nib_lo_ff));
    assign push_rs    = par_mode ? rs_s : ser_rs_ff;
    assign push_data  = !par_mode ? {ser_sh_ff[6:0], pin_s2_ff[`VHP_PIN_SI]} :
                        w8 ? db_s : {nib_hi_ff, db_s[7:4]};
    assign rd_fetch   = ser_rd_fetch || (p_rd_start && (w8 || !rd_nib_lo_ff));
    assign rd_rs      = par_mode ? rs_s : ser_sh_ff[`VHP_SER_RS_BIT - 1];

    // Two-entry write buffer in front of the register core
    logic [8:0] fifo_mem [FIFO_DEPTH];
    logic [PW-1:0] wr_ptr_ff, rd_ptr_ff;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic in_ready, out_valid, out_ready, do_push, do_pop, pop_rs;
    vhp_byte_t pop_data;
    assign in_ready  = cnt_ff != CW'(FIFO_DEPTH);
    assign out_valid = cnt_ff != '0;
    assign out_ready = !rd_fetch && !disp_req;
    assign do_push   = push_valid && in_ready;
    assign do_pop    = out_valid && out_ready;
    assign pop_rs    = fifo_mem[rd_ptr_ff][8];
    assign pop_data  = fifo_mem[rd_ptr_ff][7:0];
    assign nxt_cnt   = cnt_ff + CW'(do_push) - CW'(do_pop);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
            write_ready <= 1'b1;
        end else begin
            cnt_ff      <= nxt_cnt;
            write_ready <= nxt_cnt != CW'(FIFO_DEPTH);
            if (do_push)
                wr_ptr_ff <= (wr_ptr_ff == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_ff + PW'(1);
            if (do_pop)
                rd_ptr_ff <= (rd_ptr_ff == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_ff + PW'(1);
        end
    end
    always_ff @(posedge sys_clk) begin
        if (do_push)
            fifo_mem[wr_ptr_ff] <= {push_rs, push_data};
    end

    // Command register, address counter and RAM target
    vhp_byte_t cmd_ff;
    vhp_addr_t ac_ff;
    vhp_ram_sel_t sel_ff;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ff <= 8'h00;
            ac_ff  <= 7'h00;
            sel_ff <= VHP_SEL_DISPLAY;
        end else if (rd_fetch && rd_rs) begin
            ac_ff <= ac_step(ac_ff, sel_ff);
        end else if (do_pop && !pop_rs) begin
            cmd_ff <= pop_data;
            if (pop_data[`VHP_CMD_DD_SET_BIT]) begin
                ac_ff  <= pop_data[`VHP_AC_MSB:0];
                sel_ff <= VHP_SEL_DISPLAY;
            end else if (pop_data[`VHP_CMD_CG_SET_BIT]) begin
                ac_ff  <= {1'b0, pop_data[`VHP_CG_ADDR_MSB:0]};
                sel_ff <= VHP_SEL_GLYPH;
            end
        end else if (do_pop) begin
            ac_ff <= ac_step(ac_ff, sel_ff);
        end
    end

    // Display code and glyph storage
    vhp_byte_t dd_ram [`VHP_DD_DEPTH];
    vhp_byte_t cg_ram [`VHP_CG_DEPTH];
    vhp_addr_t ac_phys;
    assign ac_phys = phys_idx(ac_ff, two_line);
    always_ff @(posedge sys_clk) begin
        if (do_pop && pop_rs) begin
            if (sel_ff == VHP_SEL_GLYPH)
                cg_ram[ac_ff[5:0]] <= pop_data;
            else if (dd_valid(ac_ff, two_line))
                dd_ram[ac_phys] <= pop_data;
        end
    end

    // Transfer register: byte captured for the host on each read
    vhp_byte_t xfer_ff, ram_rd;
    always_comb begin
        if (sel_ff == VHP_SEL_GLYPH)
            ram_rd = cg_ram[ac_ff[5:0]];
        else if (dd_valid(ac_ff, two_line))
            ram_rd = dd_ram[ac_phys];
        else
            ram_rd = 8'h00;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            xfer_ff <= 8'h00;
        else if (rd_fetch)
            xfer_ff <= rd_rs ? ram_rd : {1'b0, ac_ff};
    end

    // Parallel read drive; in 4-bit mode nibbles share the upper lanes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_data_pins_out  <= 8'h00;
            host_data_pins_oe_n <= 1'b1;
        end else begin
            host_data_pins_oe_n <= !p_rd_act;
            if (w8)
                host_data_pins_out <= rd_fetch ? (rd_rs ? ram_rd : {1'b0, ac_ff}) : xfer_ff;
            else if (rd_fetch)
                host_data_pins_out <= rd_rs ? {ram_rd[7:4], 4'h0} : {1'b0, ac_ff[6:4], 4'h0};
            else if (p_rd_start)
                host_data_pins_out <= {xfer_ff[3:0], 4'h0};
        end
    end

    // Serial read drive, most significant bit first
    logic [7:0] ser_out_sh_ff;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_out_sh_ff <= 8'h00;
            serial_out    <= 1'b0;
            serial_oe_n   <= 1'b1;
        end else begin
            serial_oe_n <= !(stb_s && ser_st_ff == VHP_SER_DATA && ser_rw_ff);
            if (ser_rd_fetch) begin
                ser_out_sh_ff <= {(rd_rs ? ram_rd[6:0] : ac_ff), 1'b0};
                serial_out    <= rd_rs ? ram_rd[7] : 1'b0;
            end else if (sck_fall && ser_st_ff == VHP_SER_DATA) begin
                ser_out_sh_ff <= {ser_out_sh_ff[6:0], 1'b0};
                serial_out    <= ser_out_sh_ff[7];
            end
        end
    end

    // Shift offset, wrapping over 80 cells or 40 per line
    vhp_addr_t shift_ff, wrap_last;
    assign wrap_last = two_line ? `VHP_LINE_LAST : `VHP_DD_LAST;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            shift_ff <= 7'h00;
        else if (shift_left && !shift_right)
            shift_ff <= (shift_ff >= wrap_last) ? 7'h00 : shift_ff + 7'h01;
        else if (shift_right && !shift_left)
            shift_ff <= (shift_ff == 7'h00) ? wrap_last : shift_ff - 7'h01;
    end

    // Display fetch: position plus offset, wrapped in its line; the room left avoids a 7-bit overflow
    vhp_addr_t pos_room, pos_wrap, line_addr;
    assign pos_room  = wrap_last - shift_ff;
    assign pos_wrap  = (disp_pos > pos_room) ? disp_pos - pos_room - 7'h01 : disp_pos + shift_ff;
    assign line_addr = (two_line && disp_line) ? (`VHP_LINE2_BASE | pos_wrap) : pos_wrap;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            disp_code <= 8'h00;
            disp_addr <= 7'h00;
            disp_ext  <= 1'b0;
        end else if (disp_req) begin
            disp_addr <= line_addr;
            disp_code <= dd_ram[phys_idx(line_addr, two_line)];
            disp_ext  <= disp_pos >= `VHP_DEV_POSITIONS;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_cmd_pop;
        do_pop && !pop_rs;
    endsequence
    sequence s_dd_set;
        s_cmd_pop ##0 pop_data[`VHP_CMD_DD_SET_BIT];
    endsequence

    busy_low_a: assert property (rd_fetch && !rd_rs |=> !xfer_ff[`VHP_BUSY_BIT])
        else $error("busy flag read high");
    status_ac_a: assert property (rd_fetch && !rd_rs |=> xfer_ff[6:0] == $past(ac_ff))
        else $error("status read lost address counter");
    cmd_load_a: assert property (s_cmd_pop |=> cmd_ff == $past(pop_data))
        else $error("command register not loaded");
    addr_set_a: assert property (s_dd_set |=> ac_ff == $past(pop_data[6:0]) && sel_ff == VHP_SEL_DISPLAY)
        else $error("address set did not load counter");
    glyph_sel_a: assert property (s_cmd_pop ##0 (!pop_data[7] && pop_data[6]) |=> sel_ff == VHP_SEL_GLYPH)
        else $error("glyph target not selected");
    ac_step_a: assert property (do_pop && pop_rs && !rd_fetch |=> ac_ff == ac_step($past(ac_ff), sel_ff))
        else $error("counter did not step after write");
    sel_hold_a: assert property (!(do_pop && !pop_rs) |=> $stable(sel_ff))
        else $error("target changed without command");
    wrap_right_a: assert property (shift_right && !shift_left && shift_ff == 7'h00 |=> shift_ff == $past(wrap_last))
        else $error("right shift did not wrap");
    one_link_a: assert property (!par_mode |-> ##1 host_data_pins_oe_n)
        else $error("parallel drive in serial mode");
    ext_pos_a: assert property (disp_req && disp_pos < `VHP_DEV_POSITIONS |=> !disp_ext)
        else $error("device position sent to extension");
    fifo_ready_a: assert property (push_valid && !write_ready |=> $stable(wr_ptr_ff))
        else $error("write accepted while buffer full");

endmodule

// ===== src/vhp_pkg.sv
package vhp_pkg;

    // Target of data transfers, chosen by the address-setting command
    typedef enum logic {
        VHP_SEL_DISPLAY,
        VHP_SEL_GLYPH
    } vhp_ram_sel_t;

    // Serial frame phase
    typedef enum logic {
        VHP_SER_CTRL,
        VHP_SER_DATA
    } vhp_ser_state_t;

    typedef logic [6:0] vhp_addr_t;
    typedef logic [7:0] vhp_byte_t;

endpackage

// ===== verification/vhp_host_model.sv
`timescale 1ns/10ps
// Host processor on the far side of the parallel and serial links
module vhp_host_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] host_data_pins_out,
    input  wire logic       host_data_pins_oe_n,
    input  wire logic       serial_out,
    input  wire logic       serial_oe_n,
    output logic            link_type_select,
    output logic            host_style_select,
    output logic            bus_width8,
    output logic            cs_n,
    output logic            register_select,
    output logic            enable_strobe,
    output logic            read_write,
    output logic            serial_in,
    output logic [7:0]      host_data_pins_in
);
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Pick the link; pins unused by it are tied to fixed levels
    task automatic set_mode(input logic par, input logic sty, input logic w8);
        link_type_select = par;
        host_style_select = par & sty;
        bus_width8 = par & w8;
        read_write = par;
        enable_strobe = par ? ~sty : 1'b1;
        register_select = ~par;
        serial_in = 1'b0;
        host_data_pins_in = 8'h00;
        cs_n = 1'b1;
        cyc(6);
    endtask

    initial begin
        set_mode(1'b1, 1'b1, 1'b1);
    end

    // One bus cycle in either strobe style; bus shows inverted garbage when released
    task automatic xfer(input logic rs, input logic rd, input logic [7:0] d, output logic [7:0] q,
                        output logic to);
        int n;
        q = 8'h00;
        n = 0;
        cs_n = 1'b0;
        register_select = rs;
        host_data_pins_in = rd ? ~host_data_pins_in : d;
        if (host_style_select) begin
            read_write = rd;
            enable_strobe = 1'b1;
        end else if (rd) begin
            enable_strobe = 1'b0;
        end else begin
            read_write = 1'b0;
        end
        while (rd && host_data_pins_oe_n !== 1'b0 && n < 16) begin
            cyc(1);
            n++;
        end
        to = (n == 16);
        q = host_data_pins_out;
        cyc(5);
        enable_strobe = ~host_style_select;
        if (!host_style_select) read_write = 1'b1;
        cyc(5);
        read_write = 1'b1;
        host_data_pins_in = ~host_data_pins_in;
        cs_n = 1'b1;
        cyc(2);
    endtask

    // Byte write; in 4-bit mode high nibble first on the upper pins
    task automatic wr(input logic rs, input logic [7:0] d);
        logic [7:0] q;
        logic       to;
        if (bus_width8) xfer(rs, 1'b0, d, q, to);
        else begin
            xfer(rs, 1'b0, {d[7:4], 4'h0}, q, to);
            xfer(rs, 1'b0, {d[3:0], 4'h0}, q, to);
        end
    endtask

    task automatic rd(input logic rs, output logic [7:0] q, output logic to);
        logic [7:0] h;
        logic       t2;
        xfer(rs, 1'b1, 8'h00, q, to);
        if (!bus_width8) begin
            h = q;
            xfer(rs, 1'b1, 8'h00, q, t2);
            q = {h[7:4], q[7:4]};
            to = to | t2;
        end
    endtask

    // Serial frame: control byte then one data byte, MSB first; clock idles high
    task automatic ser_xfer(input logic rd, input logic rs, input logic [7:0] d, output logic [7:0] q);
        logic [7:0] c;
        c = {5'h00, rd, rs, 1'b0};
        q = 8'h00;
        cs_n = 1'b0;
        register_select = 1'b0;
        cyc(8);
        for (int k = 15; k >= 0; k--) begin
            enable_strobe = 1'b0;
            serial_in = (k > 7) ? c[k-8] : d[k];
            cyc(8);
            enable_strobe = 1'b1;
            cyc(8);
            // A line the device does not drive shows the inverse of its last level
            if (rd && k <= 8 && k >= 1) q[k-1] = serial_oe_n ? ~serial_out : serial_out;
        end
        register_select = 1'b1;
        cs_n = 1'b1;
        cyc(8);
    endtask
endmodule

// ===== verification/vhp_host_port_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the host port
module vhp_host_port_tb;
    import vhp_pkg::*;
    logic       sys_clk = 1'b0;
    logic       rst_n, lts, hss, w8, cs_n, rs, en, rw, si, so, so_oe_n, wready, oe_n;
    logic       two_line, shift_left, shift_right, disp_req, disp_line, disp_ext;
    logic [7:0] dout, din;
    logic [6:0] disp_pos;
    vhp_byte_t  disp_code;
    vhp_addr_t  disp_addr;
    int         errors;
    int         compares;

    always #2 sys_clk = ~sys_clk;

    vhp_host_port u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .link_type_select(lts), .host_style_select(hss),
        .bus_width8(w8), .cs_n(cs_n), .register_select(rs), .enable_strobe(en), .read_write(rw),
        .serial_in(si), .host_data_pins_in(din), .host_data_pins_out(dout), .host_data_pins_oe_n(oe_n),
        .serial_out(so), .serial_oe_n(so_oe_n), .write_ready(wready), .two_line(two_line),
        .shift_left(shift_left), .shift_right(shift_right), .disp_req(disp_req), .disp_line(disp_line),
        .disp_pos(disp_pos), .disp_code(disp_code), .disp_addr(disp_addr), .disp_ext(disp_ext));

    vhp_host_model u_host (.sys_clk(sys_clk), .host_data_pins_out(dout), .host_data_pins_oe_n(oe_n),
        .serial_out(so), .serial_oe_n(so_oe_n), .link_type_select(lts), .host_style_select(hss),
        .bus_width8(w8), .cs_n(cs_n), .register_select(rs), .enable_strobe(en), .read_write(rw),
        .serial_in(si), .host_data_pins_in(din));

    task automatic conclude();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Read through the host and compare; a hung read ends the run
    task automatic rdc(input logic r, input logic [7:0] exp);
        logic [7:0] q;
        logic       to;
        u_host.rd(r, q, to);
        if (to) begin
            errors++;
            $display("[ERR] t=%0t read timeout got=%h exp=%h", $time, q, exp);
            conclude();
        end else begin
            chk(q, exp);
        end
    endtask

    task automatic fetch(input logic ln, input logic [6:0] pos, input logic [6:0] ea, input logic ee);
        disp_line = ln;
        disp_pos = pos;
        disp_req = 1'b1;
        @(negedge sys_clk);
        disp_req = 1'b0;
        chk({1'b0, disp_addr}, {1'b0, ea});
        chk({7'h00, disp_ext}, {7'h00, ee});
    endtask

    task automatic shift(input logic l);
        shift_left = l;
        shift_right = ~l;
        @(negedge sys_clk);
        shift_left = 1'b0;
        shift_right = 1'b0;
        @(negedge sys_clk);
    endtask

    // Status, address set, data write and read-back with counter steps
    task automatic t_regs();
        rdc(1'b0, 8'h00);
        u_host.wr(1'b0, 8'hce);
        rdc(1'b0, 8'h4e);
        u_host.wr(1'b1, 8'ha5);
        u_host.wr(1'b1, 8'h5a);
        u_host.wr(1'b0, 8'h12);
        rdc(1'b0, 8'h50);
        u_host.wr(1'b0, 8'hce);
        rdc(1'b1, 8'ha5);
        rdc(1'b1, 8'h5a);
        rdc(1'b0, 8'h50);
        $display("test regs done");
    endtask

    task automatic t_glyph();
        u_host.wr(1'b0, 8'h85);
        u_host.wr(1'b1, 8'h77);
        u_host.wr(1'b0, 8'h45);
        u_host.wr(1'b1, 8'h11);
        rdc(1'b0, 8'h06);
        u_host.wr(1'b0, 8'h45);
        rdc(1'b1, 8'h11);
        u_host.wr(1'b0, 8'h85);
        rdc(1'b1, 8'h77);
        $display("test glyph done");
    endtask

    // Stalled buffer: two bytes kept, third refused
    task automatic t_buf();
        u_host.wr(1'b0, 8'ha0);
        disp_req = 1'b1;
        u_host.wr(1'b1, 8'h01);
        u_host.wr(1'b1, 8'h02);
        u_host.wr(1'b1, 8'h03);
        chk({7'h00, wready}, 8'h00);
        disp_req = 1'b0;
        repeat (6) @(negedge sys_clk);
        rdc(1'b0, 8'h22);
        u_host.wr(1'b0, 8'ha0);
        rdc(1'b1, 8'h01);
        rdc(1'b1, 8'h02);
        $display("test buffer done");
    endtask

    // Split strobes on a 4-bit bus, then serial status, write, address set and read-back
    task automatic t_links();
        logic [7:0] q;
        u_host.set_mode(1'b1, 1'b0, 1'b0);
        u_host.wr(1'b0, 8'h90);
        rdc(1'b0, 8'h10);
        u_host.wr(1'b1, 8'hc3);
        u_host.set_mode(1'b1, 1'b1, 1'b1);
        u_host.wr(1'b0, 8'h90);
        rdc(1'b1, 8'hc3);
        u_host.set_mode(1'b0, 1'b0, 1'b0);
        u_host.ser_xfer(1'b1, 1'b0, 8'h00, q);
        chk(q, 8'h11);
        u_host.ser_xfer(1'b0, 1'b1, 8'h3c, q);
        u_host.ser_xfer(1'b0, 1'b0, 8'h91, q);
        u_host.ser_xfer(1'b1, 1'b1, 8'h00, q);
        chk(q, 8'h3c);
        u_host.ser_xfer(1'b1, 1'b0, 8'h00, q);
        chk(q, 8'h12);
        u_host.set_mode(1'b1, 1'b1, 1'b1);
        $display("test links done");
    endtask

    // Window mapping in both layouts, with shifts and wrap-around
    task automatic t_disp();
        two_line = 1'b0;
        fetch(1'b0, 7'h00, 7'h00, 1'b0);
        fetch(1'b0, 7'h17, 7'h17, 1'b0);
        fetch(1'b0, 7'h18, 7'h18, 1'b1);
        shift(1'b1);
        fetch(1'b0, 7'h00, 7'h01, 1'b0);
        shift(1'b0);
        shift(1'b0);
        fetch(1'b0, 7'h00, 7'h4f, 1'b0);
        chk(disp_code, 8'h5a);
        shift(1'b1);
        two_line = 1'b1;
        fetch(1'b1, 7'h00, 7'h40, 1'b0);
        fetch(1'b0, 7'h27, 7'h27, 1'b1);
        shift(1'b0);
        fetch(1'b0, 7'h00, 7'h27, 1'b0);
        fetch(1'b1, 7'h00, 7'h67, 1'b0);
        shift(1'b1);
        $display("test display done");
    endtask

    initial begin
        errors = 0;
        compares = 0;
        rst_n = 1'b0;
        two_line = 1'b0;
        shift_left = 1'b0;
        shift_right = 1'b0;
        disp_req = 1'b0;
        disp_line = 1'b0;
        disp_pos = 7'h00;
        repeat (3) @(negedge sys_clk);
        chk({6'h00, oe_n, wready}, 8'h03);
        rst_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        t_regs();
        t_glyph();
        t_buf();
        t_links();
        t_disp();
        conclude();
    end
endmodule
